// ==== gpt_timer_core.sv ====
// 16-bit rtos timer and 32-bit wide timer with register port
// ************************************************************
// ************************************************************
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_consts.svh"
module gpt_timer_core
  import gpt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [31:0] regRdData,
  // asynchronous count sources
  input wire logic srcSlowClk,
  input wire logic srcUclk,
  input wire logic srcEdgePin,
  // events
  output logic rtosIrq,
  output logic wideIrq,
  output logic rtosAdcStart,
  output logic wideAdcStart
);
  // ************************************************************
  // time-of-day arithmetic
  // ************************************************************
  function automatic gpt_word_t todInc(input gpt_word_t v,
    input logic [7:0] hmax);
    gpt_tod_s t;
    t = v;
    t.rsvA = '0;
    t.rsvB = '0;
    t.rsvC = 1'b0;
    if (t.frac != `GPT_FRAC_MAX)
      t.frac = t.frac + 7'h01;
    else
    begin
      t.frac = '0;
      if (t.seconds != `GPT_SEC_MAX)
        t.seconds = t.seconds + 6'h01;
      else
      begin
        t.seconds = '0;
        if (t.minutes != `GPT_SEC_MAX)
          t.minutes = t.minutes + 6'h01;
        else
        begin
          t.minutes = '0;
          t.hours = (t.hours >= hmax) ? 8'h00 : t.hours + 8'h01;
        end
      end
    end
    todInc = t;
  endfunction : todInc

  function automatic gpt_word_t todDec(input gpt_word_t v,
    input logic [7:0] hmax);
    gpt_tod_s t;
    t = v;
    t.rsvA = '0;
    t.rsvB = '0;
    t.rsvC = 1'b0;
    if (t.frac != 7'h00)
      t.frac = t.frac - 7'h01;
    else
    begin
      t.frac = `GPT_FRAC_MAX;
      if (t.seconds != 6'h00)
        t.seconds = t.seconds - 6'h01;
      else
      begin
        t.seconds = `GPT_SEC_MAX;
        if (t.minutes != 6'h00)
          t.minutes = t.minutes - 6'h01;
        else
        begin
          t.minutes = `GPT_SEC_MAX;
          t.hours = (t.hours == 8'h00) ? hmax : t.hours - 8'h01;
        end
      end
    end
    todDec = t;
  endfunction : todDec

  // one count step in either format and direction
  function automatic gpt_word_t wideStepOf(input gpt_word_t v,
    input logic up, input logic tod, input logic [7:0] hmax);
    if (tod)
      wideStepOf = up ? todInc(v, hmax) : todDec(v, hmax);
    else
      wideStepOf = up ? v + 32'h1 : v - 32'h1;
  endfunction : wideStepOf

  // ************************************************************
  // source synchronisers
  // ************************************************************
  logic [2:0] pinS1;
  logic [2:0] pinS2;
  logic [2:0] pinS3;
  logic [2:0] pinLvl;
  wire logic [2:0] pinRise;

  // three stages; a rise counts once stages two and three are both high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinS1 <= '0;
      pinS2 <= '0;
      pinS3 <= '0;
      pinLvl <= '0;
    end
    else
    begin
      pinS1 <= {srcEdgePin, srcUclk, srcSlowClk};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinLvl <= (pinS2 & pinS3) | (pinLvl & (pinS2 | pinS3));
    end
  end
  assign pinRise = pinS2 & pinS3 & ~pinLvl;

  // ************************************************************
  // register decode
  // ************************************************************
  wire logic wrRtosReload = regWrStrobe && regAddr == `GPT_RTOS_RELOAD;
  wire logic wrRtosCtrl = regWrStrobe && regAddr == `GPT_RTOS_CTRL;
  wire logic wrRtosClr = regWrStrobe && regAddr == `GPT_RTOS_CLR;
  wire logic wrWideReload = regWrStrobe && regAddr == `GPT_WIDE_RELOAD;
  wire logic wrWideCtrl = regWrStrobe && regAddr == `GPT_WIDE_CTRL;
  wire logic wrWideClr = regWrStrobe && regAddr == `GPT_WIDE_CLR;

  logic [15:0] rtosReload;
  logic [15:0] rtosCtrl;
  logic [15:0] rtosCount;
  logic rtosLoad;
  gpt_word_t wideReload;
  gpt_word_t wideCtrl;
  gpt_word_t wideCount;
  logic wideLoad;

  // software registers; a control write schedules a load
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rtosReload <= `GPT_RTOS_LD_RST;
      rtosCtrl <= `GPT_RTOS_LD_RST;
      wideReload <= `GPT_WORD_ZERO;
      wideCtrl <= `GPT_WORD_ZERO;
      rtosLoad <= 1'b0;
      wideLoad <= 1'b0;
    end
    else
    begin
      if (wrRtosReload)
        rtosReload <= regWrData[15:0];
      if (wrRtosCtrl)
        rtosCtrl <= regWrData[15:0] & `GPT_RTOS_CTRL_MASK;
      if (wrWideReload)
        wideReload <= regWrData;
      if (wrWideCtrl)
        wideCtrl <= regWrData & `GPT_WIDE_CTRL_MASK;
      rtosLoad <= wrRtosCtrl;
      wideLoad <= wrWideCtrl;
    end
  end

  // ************************************************************
  // rtos timer
  // ************************************************************
  gpt_tick_if rtosTk ();
  wire logic rtosEn = rtosCtrl[`GPT_EN_BIT];
  wire logic rtosPer = rtosCtrl[`GPT_PER_BIT];
  wire logic [1:0] rtosPsc = rtosCtrl[`GPT_PSC_HI:`GPT_PSC_LO];
  assign rtosTk.run = rtosEn;
  assign rtosTk.restart = rtosLoad;
  assign rtosTk.srcEdge = 1'b1; // core clock only
  assign rtosTk.divSel = (rtosPsc == `GPT_DIV32K) ? `GPT_DIV1 : rtosPsc;

  gpt_prescaler #(.PSC_W(`GPT_PSC_MIN_W)) rtosPre (
    .clk(clk),
    .sys_rst(sys_rst),
    .tk(rtosTk)
  );

  wire logic rtosAdv = rtosTk.tick && !rtosLoad;
  // periodic reloads one step in, so the period is reload ticks
  wire logic [15:0] rtosStep = (rtosPer && rtosCount == 16'h0) ?
    rtosReload - 16'h1 : rtosCount - 16'h1;
  wire logic rtosEvent = rtosAdv && rtosStep == 16'h0;
  wire logic [15:0] next_rtosCount = rtosLoad ?
    (rtosPer ? rtosReload : `GPT_RTOS_CNT_RST) :
    (rtosAdv ? rtosStep : rtosCount);

  // ************************************************************
  // wide timer
  // ************************************************************
  gpt_tick_if wideTk ();
  wire logic wideEn = wideCtrl[`GPT_EN_BIT];
  wire logic widePer = wideCtrl[`GPT_PER_BIT];
  wire logic wideUp = wideCtrl[`GPT_UP_BIT];
  wire logic [1:0] wideFmt = wideCtrl[`GPT_FMT_HI:`GPT_FMT_LO];
  wire logic [2:0] wideSrc = wideCtrl[`GPT_CLK_HI:`GPT_CLK_LO];
  wire logic wideTod = wideFmt == `GPT_FMT_TOD23 ||
    wideFmt == `GPT_FMT_TOD255;
  wire logic [7:0] wideHmax = (wideFmt == `GPT_FMT_TOD255) ?
    `GPT_HR_MAX255 : `GPT_HR_MAX24;
  wire gpt_word_t wideFull = wideTod ? {wideHmax, 2'b00, `GPT_SEC_MAX,
    2'b00, `GPT_SEC_MAX, 1'b0, `GPT_FRAC_MAX} : `GPT_WIDE_CNT_RST;
  wire gpt_word_t wideTerm = wideUp ? wideFull : `GPT_WORD_ZERO;
  wire gpt_tod_s wideTodView = wideCount;

  assign wideTk.run = wideEn;
  assign wideTk.restart = wideLoad;
  assign wideTk.divSel = wideCtrl[`GPT_PSC_HI:`GPT_PSC_LO];
  assign wideTk.srcEdge = (wideSrc == `GPT_SRC_CORE) ? 1'b1 :
    (wideSrc == `GPT_SRC_SLOW) ? pinRise[0] :
    (wideSrc == `GPT_SRC_UCLK) ? pinRise[1] :
    (wideSrc == `GPT_SRC_PIN) ? pinRise[2] : 1'b0;

  gpt_prescaler #(.PSC_W(`GPT_PSC_MIN_W)) widePre (
    .clk(clk),
    .sys_rst(sys_rst),
    .tk(wideTk)
  );

  wire logic wideAdv = wideTk.tick && !wideLoad;
  // up: period is full minus reload ticks
  wire gpt_word_t wideStep = (widePer && wideCount == wideTerm) ?
    wideStepOf(wideReload, wideUp, wideTod, wideHmax) :
    wideStepOf(wideCount, wideUp, wideTod, wideHmax);
  wire logic wideEvent = wideAdv && wideStep == wideTerm;
  wire gpt_word_t wideStart = widePer ? wideReload :
    (wideUp ? `GPT_WORD_ZERO : wideFull);
  wire gpt_word_t next_wideCount = wideLoad ? wideStart :
    (wideAdv ? wideStep : wideCount);

  // ************************************************************
  // counters and interrupt flags
  // ************************************************************
  wire logic next_rtosIrq = rtosEvent || (rtosIrq && !wrRtosClr);
  wire logic next_wideIrq = wideEvent || (wideIrq && !wrWideClr);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rtosCount <= `GPT_RTOS_CNT_RST;
      wideCount <= `GPT_WIDE_CNT_RST;
      rtosIrq <= 1'b0;
      wideIrq <= 1'b0;
      rtosAdcStart <= 1'b0;
      wideAdcStart <= 1'b0;
    end
    else
    begin
      rtosCount <= next_rtosCount;
      wideCount <= next_wideCount;
      rtosIrq <= next_rtosIrq;
      wideIrq <= next_wideIrq;
      rtosAdcStart <= rtosEvent;
      wideAdcStart <= wideEvent;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  wire logic rdRtosCount = regAddr == `GPT_RTOS_COUNT;
  gpt_word_t rdMux;

  // value reads sample the live count without touching it
  always_comb
  begin
    if (regAddr == `GPT_RTOS_RELOAD)
      rdMux = {16'h0000, rtosReload};
    else if (rdRtosCount)
      rdMux = {16'h0000, rtosCount};
    else if (regAddr == `GPT_RTOS_CTRL)
      rdMux = {16'h0000, rtosCtrl};
    else if (regAddr == `GPT_WIDE_RELOAD)
      rdMux = wideReload;
    else if (regAddr == `GPT_WIDE_COUNT)
      rdMux = wideCount;
    else if (regAddr == `GPT_WIDE_CTRL)
      rdMux = wideCtrl;
    else if (regAddr == `GPT_IRQ_STATUS)
      rdMux = {30'h0, wideIrq, rtosIrq};
    else
      rdMux = `GPT_WORD_ZERO;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      regRdData <= `GPT_WORD_ZERO;
    else
      regRdData <= regRdStrobe ? rdMux : `GPT_WORD_ZERO;
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence countRead;
    regRdStrobe && rdRtosCount;
  endsequence
  sequence ctrlPeriodicWrite;
    wrRtosCtrl && regWrData[`GPT_PER_BIT] ##1 rtosLoad;
  endsequence

  count_read_a: assert property (
    countRead |=> regRdData == {16'h0000, $past(rtosCount)})
    else $error("count read mismatch");
  ctrl_load_a: assert property (
    ctrlPeriodicWrite |=> rtosCount == $past(rtosReload))
    else $error("periodic start not from reload");
  rtos_step_a: assert property (
    rtosAdv && rtosCount != 16'h0 |=> rtosCount == $past(rtosCount) - 16'h1)
    else $error("rtos count did not step down");
  free_wrap_a: assert property (
    rtosAdv && !rtosPer && rtosCount == 16'h0 |=>
    rtosCount == `GPT_RTOS_CNT_RST) else $error("free run did not wrap");
  rtos_div1_a: assert property (
    rtosEn && rtosPsc == `GPT_DIV32K && !rtosLoad |-> rtosTk.tick)
    else $error("prescale code 3 not divide by 1");
  rtos_irq_hold_a: assert property (
    rtosIrq && !wrRtosClr |=> rtosIrq) else $error("irq dropped early");
  irq_clear_a: assert property (
    wrWideClr && !wideEvent |=> !wideIrq) else $error("irq not cleared");
  adc_start_a: assert property (
    rtosEvent |=> rtosAdcStart && rtosIrq && rtosCount == 16'h0)
    else $error("no adc start at terminal count");
  wide_irq_a: assert property (
    wideEvent |=> wideIrq && wideCount == $past(wideTerm))
    else $error("wide terminal without irq");
  tod_fields_a: assert property (
    wideTod && wideAdv |=> wideTodView.rsvA == 2'b00 &&
    wideTodView.rsvB == 2'b00 && !wideTodView.rsvC)
    else $error("reserved time bits set");
  tod_roll_a: assert property (
    wideTod && wideAdv && wideUp && wideCount != wideTerm &&
    wideTodView.frac == `GPT_FRAC_MAX |=> wideTodView.frac == 7'h00 &&
    wideTodView.seconds != $past(wideTodView.seconds))
    else $error("fraction did not roll into seconds");
endmodule : gpt_timer_core
`default_nettype wire

// ==== gpt_consts.svh ====
// register offsets, field positions, reset values and counts of the timer
`ifndef GPT_CONSTS_SVH
`define GPT_CONSTS_SVH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define GPT_RTOS_RELOAD 32'hffff0300
`define GPT_RTOS_COUNT 32'hffff0304
`define GPT_RTOS_CTRL 32'hffff0308
`define GPT_RTOS_CLR 32'hffff030c
`define GPT_WIDE_RELOAD 32'hffff0320
`define GPT_WIDE_COUNT 32'hffff0324
`define GPT_WIDE_CTRL 32'hffff0328
`define GPT_WIDE_CLR 32'hffff032c
`define GPT_IRQ_STATUS 32'hffff0340
// ************************************************************
// control fields
// ************************************************************
`define GPT_UP_BIT 8
`define GPT_EN_BIT 7
`define GPT_PER_BIT 6
`define GPT_FMT_HI 5
`define GPT_FMT_LO 4
`define GPT_PSC_HI 3
`define GPT_PSC_LO 2
`define GPT_CLK_HI 11
`define GPT_CLK_LO 9
`define GPT_RTOS_CTRL_MASK 16'h00fc
`define GPT_WIDE_CTRL_MASK 32'h00000ffc
`define GPT_STAT_RTOS 0
`define GPT_STAT_WIDE 1
// ************************************************************
// reset values
// ************************************************************
`define GPT_RTOS_CNT_RST 16'hffff
`define GPT_WIDE_CNT_RST 32'hffffffff
`define GPT_RTOS_LD_RST 16'h0000
`define GPT_WORD_ZERO 32'h00000000
// ************************************************************
// prescale codes and terminal counts
// ************************************************************
`define GPT_DIV1 2'h0
`define GPT_DIV16 2'h1
`define GPT_DIV256 2'h2
`define GPT_DIV32K 2'h3
`define GPT_DIV1_TOP 15'h0000
`define GPT_DIV16_TOP 15'h000f
`define GPT_DIV256_TOP 15'h00ff
`define GPT_DIV32K_TOP 15'h7fff
`define GPT_PSC_MIN_W 15
// ************************************************************
// clock sources and count formats
// ************************************************************
`define GPT_SRC_CORE 3'h0
`define GPT_SRC_SLOW 3'h1
`define GPT_SRC_UCLK 3'h2
`define GPT_SRC_PIN 3'h3
`define GPT_FMT_TOD23 2'h2
`define GPT_FMT_TOD255 2'h3
`define GPT_FRAC_MAX 7'h7f
`define GPT_SEC_MAX 6'h3b
`define GPT_HR_MAX24 8'h17
`define GPT_HR_MAX255 8'hff
`endif

// ==== gpt_pkg.sv ====
// types shared by the timer modules
`default_nettype none
package gpt_pkg;
  typedef logic [31:0] gpt_word_t;
  // time-of-day layout of the wide counter
  typedef struct packed {
    logic [7:0] hours;
    logic [1:0] rsvA;
    logic [5:0] minutes;
    logic [1:0] rsvB;
    logic [5:0] seconds;
    logic rsvC;
    logic [6:0] frac;
  } gpt_tod_s;
endpackage : gpt_pkg
`default_nettype wire

// ==== gpt_tick_if.sv ====
// link between a counter and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface gpt_tick_if;
  logic run;
  logic restart;
  logic srcEdge;
  logic [1:0] divSel;
  logic tick;
  modport ctrl (output run, output restart, output srcEdge, output divSel,
    input tick);
  modport pre (input run, input restart, input srcEdge, input divSel,
    output tick);
endinterface : gpt_tick_if
`default_nettype wire

// ==== gpt_prescaler.sv ====
// prescaler dividing source edges by 1, 16, 256 or 32768
`timescale 1ns/1ps
`default_nettype none
`include "gpt_consts.svh"
module gpt_prescaler
  import gpt_pkg::*;
#(
  parameter int PSC_W = 15
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // counter side
  gpt_tick_if.pre tk
);
  // ************************************************************
  // checks
  // ************************************************************
  if (PSC_W < `GPT_PSC_MIN_W)
  begin : g_bad_width
    $error("prescaler too narrow for divide by 32768");
  end

  // ************************************************************
  // divider
  // ************************************************************
  function automatic logic [PSC_W-1:0] divTop(input logic [1:0] sel);
    if (sel == `GPT_DIV16)
      divTop = PSC_W'(`GPT_DIV16_TOP);
    else if (sel == `GPT_DIV256)
      divTop = PSC_W'(`GPT_DIV256_TOP);
    else if (sel == `GPT_DIV32K)
      divTop = PSC_W'(`GPT_DIV32K_TOP);
    else
      divTop = PSC_W'(`GPT_DIV1_TOP);
  endfunction : divTop

  logic [PSC_W-1:0] count;
  logic [PSC_W-1:0] next_count;
  wire logic atTop;

  // one tick on the source edge that completes a division
  assign atTop = (count >= divTop(tk.divSel));
  assign tk.tick = tk.run && !tk.restart && tk.srcEdge && atTop;
  assign next_count = (tk.restart || !tk.run) ? '0 :
    (tk.srcEdge ? (atTop ? '0 : count + 1'b1) : count);

  // division state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      count <= '0;
    else
      count <= next_count;
  end

  psc_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    tk.tick |=> count == '0) else $error("prescaler not rewound");
endmodule : gpt_prescaler
`default_nettype wire

// ==== gpt_timer_core_test.sv ====
// self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none
`include "gpt_consts.svh"
module gpt_timer_core_test
  import gpt_pkg::*;
;
  // ******************
  // signals and design
  // ******************
  logic clk, sysRst, regWrStrobe, regRdStrobe, srcSlowClk;
  logic [31:0] regAddr, regWrData, regRdData;
  logic rtosIrq, wideIrq, rtosAdc, wideAdc;
  logic srcUclk, srcEdgePin;
  int badCount, checked;

  gpt_timer_core DUT (
    .clk(clk),
    .sys_rst(sysRst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe),
    .regRdData(regRdData),
    .srcSlowClk(srcSlowClk),
    .srcUclk(srcUclk),
    .srcEdgePin(srcEdgePin),
    .rtosIrq(rtosIrq),
    .wideIrq(wideIrq),
    .rtosAdcStart(rtosAdc),
    .wideAdcStart(wideAdc)
  );

  // core clock 25 MHz, slow source about 32768 Hz, unrelated phase
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    srcSlowClk = 1'b0;
    forever #15259 srcSlowClk = ~srcSlowClk;
  end
  // fast source, 260 ns period, unrelated phase
  initial
  begin
    srcUclk = 1'b0;
    forever #130 srcUclk = ~srcUclk;
  end

  // ******************
  // shared tasks
  // ******************
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      badCount++;
    end
  endtask : check

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // one-cycle write, entered just after a rising edge
  task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  // one-cycle read, data taken in the following cycle only
  task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    @(negedge clk);
    d = regRdData;
    @(posedge clk);
  endtask : reg_read

  task automatic expect_read(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_read(a, d);
    check(d, e);
  endtask : expect_read

  // cycles until the next terminal pulse, bounded
  task automatic wait_adc(input bit wide, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n > 20000)
      begin
        check(n, 32'h0);
        close_out();
      end
    end
    while ((wide ? wideAdc : rtosAdc) !== 1'b1);
  endtask : wait_adc

  // spacing of two terminal pulses
  task automatic measure(input bit wide, output int n);
    wait_adc(wide, n);
    wait_adc(wide, n);
    @(posedge clk);
  endtask : measure

  // stop a timer, clear its request, see it drop
  task automatic stop_clear(input bit wide);
    reg_write(wide ? `GPT_WIDE_CTRL : `GPT_RTOS_CTRL, 32'h0);
    reg_write(wide ? `GPT_WIDE_CLR : `GPT_RTOS_CLR, 32'ha5);
    check({rtosIrq, wideIrq}, 32'h0);
  endtask : stop_clear

  // ******************
  // scenarios
  // ******************
  task automatic t_reset;
    logic [31:0] a [8] = '{`GPT_RTOS_RELOAD, `GPT_RTOS_COUNT,
      `GPT_RTOS_CTRL, `GPT_WIDE_RELOAD, `GPT_WIDE_COUNT, `GPT_WIDE_CTRL,
      `GPT_IRQ_STATUS, 32'hffff0310};
    logic [31:0] e [8] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'hffffffff,
      32'h0, 32'h0, 32'h0};
    foreach (a[i]) expect_read(a[i], e[i]);
    check({rtosIrq, wideIrq, rtosAdc, wideAdc}, 32'h0);
    reg_write(`GPT_RTOS_RELOAD, 32'h12345678);
    expect_read(`GPT_RTOS_RELOAD, 32'h5678);
    reg_write(`GPT_RTOS_COUNT, 32'h0);
    expect_read(`GPT_RTOS_COUNT, 32'hffff);
    // read data stand one cycle only, then fall back to zero
    @(negedge clk);
    check(regRdData, 32'h0);
    @(posedge clk);
  endtask : t_reset

  // periodic down count at every prescale code
  task automatic t_rtos_div;
    int per [4] = '{3, 48, 768, 3};
    int n;
    reg_write(`GPT_RTOS_RELOAD, 32'h3);
    for (int p = 0; p < 4; p++)
    begin
      reg_write(`GPT_RTOS_CTRL, 32'hc0 | (32'(p) << 2));
      measure(1'b0, n);
      check(n, per[p]);
      check({rtosIrq, wideIrq}, 32'h2);
      expect_read(`GPT_IRQ_STATUS, 32'h1);
      stop_clear(1'b0);
    end
  endtask : t_rtos_div

  // free-running down count, read without disturbing
  task automatic t_free;
    logic [31:0] a, b;
    reg_write(`GPT_RTOS_CTRL, 32'h80);
    reg_read(`GPT_RTOS_COUNT, a);
    reg_read(`GPT_RTOS_COUNT, b);
    check(a - b, 32'h2);
    check(a > 32'hfff0, 32'h1);
    reg_write(`GPT_RTOS_CTRL, 32'h0);
    reg_read(`GPT_RTOS_COUNT, a);
    reg_read(`GPT_RTOS_COUNT, b);
    check(a - b, 32'h0);
  endtask : t_free

  // wide timer counting up in periodic mode
  task automatic t_wide_up;
    int n;
    reg_write(`GPT_WIDE_RELOAD, 32'hfffffff0);
    reg_write(`GPT_WIDE_CTRL, 32'h1c0);
    expect_read(`GPT_WIDE_CTRL, 32'h1c0);
    measure(1'b1, n);
    check(n, 32'hf);
    check({rtosIrq, wideIrq}, 32'h1);
    // free-running up starts from zero and steps every cycle
    reg_write(`GPT_WIDE_CTRL, 32'h180);
    expect_read(`GPT_WIDE_COUNT, 32'h0);
    expect_read(`GPT_WIDE_COUNT, 32'h2);
    stop_clear(1'b1);
  endtask : t_wide_up

  // time-of-day layout, one minute down to zero
  task automatic t_tod;
    int n;
    gpt_tod_s t;
    reg_write(`GPT_WIDE_RELOAD, 32'h00010000);
    expect_read(`GPT_WIDE_RELOAD, 32'h00010000);
    // slow source, divide by 256: loads, never steps within the run
    reg_write(`GPT_WIDE_CTRL, 32'h2e8);
    expect_read(`GPT_WIDE_CTRL, 32'h2e8);
    expect_read(`GPT_WIDE_COUNT, 32'h00010000);
    reg_write(`GPT_WIDE_CTRL, 32'he0);
    measure(1'b1, n);
    check(n, 32'd7680);
    reg_read(`GPT_WIDE_COUNT, t);
    check({t.rsvA, t.rsvB, t.rsvC}, 32'h0);
    check({t.hours, t.minutes, t.seconds}, 32'h3b);
    stop_clear(1'b1);
    // counting up with 0..255 hours, fraction rolls into seconds
    reg_write(`GPT_WIDE_RELOAD, 32'hff3b3a00);
    reg_write(`GPT_WIDE_CTRL, 32'h1f0);
    measure(1'b1, n);
    check(n, 32'd255);
    expect_read(`GPT_WIDE_COUNT, 32'hff3b3a01);
    stop_clear(1'b1);
  endtask : t_tod

  // slow asynchronous source for the wide timer
  task automatic t_slow;
    int n, k;
    logic [31:0] a, b;
    reg_write(`GPT_WIDE_RELOAD, 32'h2);
    reg_write(`GPT_WIDE_CTRL, 32'h2c0);
    measure(1'b1, n);
    check(n > 1519 && n < 1533, 32'h1);
    reg_read(`GPT_WIDE_COUNT, a);
    reg_read(`GPT_WIDE_COUNT, b);
    if (a !== b)
      reg_read(`GPT_WIDE_COUNT, b);
    check(b <= 32'h2, 32'h1);
    reg_write(`GPT_WIDE_CTRL, 32'h0);
    reg_write(`GPT_WIDE_CLR, 32'h0);
    k = 0;
    do
    begin
      reg_read(`GPT_IRQ_STATUS, a);
      k++;
    end
    while (a !== 32'h0 && k < 50);
    check(a, 32'h0);
  endtask : t_slow

  // fast clock and pin sources of the wide timer
  task automatic t_pins;
    int n;
    reg_write(`GPT_WIDE_RELOAD, 32'h4);
    reg_write(`GPT_WIDE_CTRL, 32'h4c0);
    measure(1'b1, n);
    check(n > 24 && n < 28, 32'h1);
    reg_write(`GPT_WIDE_CTRL, 32'h6c0);
    // three slow pin pulses step the count from 4 to 1
    repeat (3)
    begin
      srcEdgePin <= 1'b1;
      repeat (4) @(posedge clk);
      srcEdgePin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    expect_read(`GPT_WIDE_COUNT, 32'h1);
    stop_clear(1'b1);
  endtask : t_pins

  // ******************
  // main sequence
  // ******************
  initial
  begin
    sysRst = 1'b1;
    regAddr = 32'h0;
    regWrData = 32'h0;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    srcEdgePin = 1'b0;
    badCount = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rtos_div();
    t_free();
    t_wide_up();
    t_tod();
    t_slow();
    t_pins();
    close_out();
  end
endmodule : gpt_timer_core_test
`default_nettype wire
